/* File: rtl/isc_regs.svh */
// Constants for the two-wire bus interface host controller
`ifndef ISC_REGS_SVH
`define ISC_REGS_SVH
// ---------------------------------------------------------------------
// Device register indices on its own register port
// ---------------------------------------------------------------------
`define ISC_DV_CR1 3'h0
`define ISC_DV_CR2 3'h1
`define ISC_DV_SR2 3'h2
`define ISC_DV_DBR 3'h3
`define ISC_DV_OAR 3'h4
// Bit positions shared by command and status registers
`define ISC_B_MST 7
`define ISC_B_TRX 6
`define ISC_B_BB 5
`define ISC_B_PIN 4
`define ISC_B_AL 3
`define ISC_B_AAS 2
`define ISC_B_AD0 1
`define ISC_B_LRB 0
// Command register values, dummy data byte and zero own address
`define ISC_CR2_STOP 8'hd0
`define ISC_CR2_PIN 8'h10
`define ISC_DUMMY 8'h00
`define ISC_ZERO_ADDR 8'h00
// ---------------------------------------------------------------------
// Host registers on the software port
// ---------------------------------------------------------------------
`define ISC_R_CTRL 4'h0
`define ISC_R_SR 4'h1
`define ISC_R_EV 4'h2
`define ISC_R_MASK 4'h3
`define ISC_R_TX 4'h4
`define ISC_R_RX 4'h5
`define ISC_R_OAR 4'h6
`define ISC_R_CR1 4'h7
`define ISC_R_STATE 4'h8
// Control bits: 0..2 are go strobes, 3..4 stored modes
`define ISC_C_STOP 0
`define ISC_C_RST 1
`define ISC_C_OAR 2
`define ISC_C_FAST 3
`define ISC_C_MRX 4
// Event bits
`define ISC_E_SVC 0
`define ISC_E_RX 1
`define ISC_E_STOP 2
`define ISC_E_RST 3
`define ISC_E_ERR 4
`define ISC_NEV 5
// ---------------------------------------------------------------------
// Timing
// ---------------------------------------------------------------------
`define ISC_CLK_MHZ 200
`define ISC_TSU_STD_NS 4700
`define ISC_TSU_FAST_NS 600
`define ISC_TSU_STD_CYC ((`ISC_TSU_STD_NS*`ISC_CLK_MHZ+999)/1000)
`define ISC_TSU_FAST_CYC ((`ISC_TSU_FAST_NS*`ISC_CLK_MHZ+999)/1000)
`endif

/* File: rtl/isc_pkg.sv */
// Types shared by the two-wire bus host controller
package isc_pkg;
    // Sequencer states
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_SR_ISSUE = 4'h1,
        ST_SR_TAKE = 4'h2,
        ST_CR1 = 4'h3,
        ST_DB_ISSUE = 4'h4,
        ST_DB_TAKE = 4'h5,
        ST_DB_WR = 4'h6,
        ST_CR2_WR = 4'h7,
        ST_SETUP = 4'h8,
        ST_OAR_WR = 4'h9
    } isc_state_t;
    // Operation in progress
    typedef enum logic [1:0] {
        OP_SVC = 2'h0,
        OP_STOP = 2'h1,
        OP_RST = 2'h2
    } isc_op_t;
    // One access on the device register port
    typedef struct packed {
        logic wr;
        logic rd;
        logic [2:0] addr;
        logic [7:0] wdata;
    } isc_dev_req_t;
endpackage

/* File: rtl/isc_host.sv */
// Host controller that services the two-wire bus interface registers
//
// Implementation choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "isc_regs.svh"
module isc_host #(
    parameter int TSU_STD_CYC = `ISC_TSU_STD_CYC,
    parameter int TSU_FAST_CYC = `ISC_TSU_FAST_CYC
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic [3:0] cpu_addr,
    input wire logic [7:0] cpu_wdata,
    input wire logic cpu_wr,
    input wire logic cpu_rd,
    output logic [7:0] cpu_rdata,
    output logic irq,
    output isc_pkg::isc_dev_req_t dv_req,
    input wire logic [7:0] dv_rdata,
    input wire logic dv_irq,
    input wire logic scl_pin
);
    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    isc_pkg::isc_state_t st_q, st_d; // Sequencer
    isc_pkg::isc_op_t op_q, op_d; // Operation in flight
    isc_pkg::isc_dev_req_t req_q, req_d; // Device port access
    logic pha_q, pha_d; // Stop requested / restart phase
    logic txw_q, txw_d; // Data write carries transmit byte
    logic rxp_q, rxp_d; // Receive path after count load
    logic [`ISC_NEV-1:0] ev_q, ev_d, mask_q; // Sticky events and mask
    logic [7:0] tx_q, rx_q, oar_q, cr1_q, sr_q; // Software images
    logic fast_q, mrx_q; // Stored modes
    logic irq_q, irq_prev_q, pend_q; // Interrupt handling
    logic scl_m_q, scl_s_q; // Clock pin synchroniser
    logic [15:0] cnt_q; // Setup wait counter
    logic [15:0] need; // Setup wait length
    logic [7:0] rdata_q;
    logic ctrl_wr;

    // True when an access writes the given device register
    function automatic logic hits(isc_pkg::isc_dev_req_t r, logic [2:0] a);
        hits = r.wr && (r.addr == a);
    endfunction

    assign ctrl_wr = cpu_wr && (cpu_addr == `ISC_R_CTRL);
    assign need = fast_q ? 16'(TSU_FAST_CYC) : 16'(TSU_STD_CYC);
    assign cpu_rdata = rdata_q;
    assign irq = irq_q;
    assign dv_req = req_q;

    // ------------------------------------------------------------------
    // Pin synchroniser and interrupt edge
    // ------------------------------------------------------------------
    // Clock line is asynchronous to mclk; only the second stage is read
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            scl_m_q <= 1'b1;
            scl_s_q <= 1'b1;
        end
        else
        begin
            scl_m_q <= scl_pin;
            scl_s_q <= scl_m_q;
        end
    end

    // Device interrupt stays high until serviced, so take its rising
    // edge; a new edge in the take cycle survives the clear
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            irq_prev_q <= 1'b0;
            pend_q <= 1'b0;
        end
        else
        begin
            irq_prev_q <= dv_irq;
            if (dv_irq && !irq_prev_q)
                pend_q <= 1'b1;
            else if (st_q == isc_pkg::ST_IDLE)
                pend_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Sequencer next state
    // ------------------------------------------------------------------
    always_comb
    begin
        st_d = st_q;
        op_d = op_q;
        pha_d = pha_q;
        txw_d = txw_q;
        rxp_d = rxp_q;
        ev_d = '0;
        case (st_q)
            isc_pkg::ST_IDLE:
            begin
                // Device service first, then software commands
                pha_d = 1'b0;
                if (pend_q)
                begin
                    op_d = isc_pkg::OP_SVC;
                    st_d = isc_pkg::ST_SR_ISSUE;
                end
                else if (ctrl_wr && cpu_wdata[`ISC_C_STOP])
                begin
                    op_d = isc_pkg::OP_STOP;
                    st_d = isc_pkg::ST_SR_ISSUE;
                end
                else if (ctrl_wr && cpu_wdata[`ISC_C_RST])
                begin
                    op_d = isc_pkg::OP_RST;
                    st_d = isc_pkg::ST_CR2_WR;
                end
                else if (ctrl_wr && cpu_wdata[`ISC_C_OAR])
                begin
                    // Zero would make a start byte look like a match
                    if (oar_q == `ISC_ZERO_ADDR)
                        ev_d[`ISC_E_ERR] = 1'b1;
                    else
                        st_d = isc_pkg::ST_OAR_WR;
                end
            end
            isc_pkg::ST_SR_ISSUE:
                st_d = isc_pkg::ST_SR_TAKE;
            isc_pkg::ST_SR_TAKE:
            begin
                // Status word is on dv_rdata in this cycle
                case (op_q)
                    isc_pkg::OP_SVC:
                    begin
                        if (dv_rdata[`ISC_B_MST])
                        begin
                            // Master mode is left to software
                            ev_d[`ISC_E_SVC] = 1'b1;
                            st_d = isc_pkg::ST_IDLE;
                        end
                        else if (dv_rdata[`ISC_B_TRX])
                        begin
                            if (!dv_rdata[`ISC_B_AAS] &&
                                dv_rdata[`ISC_B_LRB])
                                st_d = isc_pkg::ST_CR2_WR;
                            else
                            begin
                                txw_d = 1'b1;
                                rxp_d = 1'b0;
                                st_d = isc_pkg::ST_CR1;
                            end
                        end
                        else if (dv_rdata[`ISC_B_AL] ||
                                 dv_rdata[`ISC_B_AAS])
                        begin
                            txw_d = 1'b0;
                            st_d = isc_pkg::ST_DB_WR;
                        end
                        else
                        begin
                            txw_d = 1'b0;
                            rxp_d = 1'b1;
                            st_d = isc_pkg::ST_CR1;
                        end
                    end
                    isc_pkg::OP_STOP:
                    begin
                        if (!pha_q)
                        begin
                            // A stop is only legal while the bus is busy
                            if (dv_rdata[`ISC_B_BB])
                                st_d = isc_pkg::ST_CR2_WR;
                            else
                            begin
                                ev_d[`ISC_E_ERR] = 1'b1;
                                st_d = isc_pkg::ST_IDLE;
                            end
                        end
                        else if (!dv_rdata[`ISC_B_BB])
                        begin
                            ev_d[`ISC_E_STOP] = 1'b1;
                            st_d = isc_pkg::ST_IDLE;
                        end
                        else
                            st_d = isc_pkg::ST_SR_ISSUE;
                    end
                    default:
                    begin
                        // Restart: busy low first, then line free
                        if (!pha_q)
                        begin
                            if (!dv_rdata[`ISC_B_BB])
                                pha_d = 1'b1;
                            st_d = isc_pkg::ST_SR_ISSUE;
                        end
                        else if (mrx_q ? scl_s_q : dv_rdata[`ISC_B_LRB])
                            st_d = isc_pkg::ST_SETUP;
                        else
                            st_d = isc_pkg::ST_SR_ISSUE;
                    end
                endcase
            end
            isc_pkg::ST_CR1:
                st_d = rxp_q ? isc_pkg::ST_DB_ISSUE : isc_pkg::ST_DB_WR;
            isc_pkg::ST_DB_ISSUE:
                st_d = isc_pkg::ST_DB_TAKE;
            isc_pkg::ST_DB_TAKE:
            begin
                ev_d[`ISC_E_RX] = 1'b1;
                st_d = isc_pkg::ST_DB_WR;
            end
            isc_pkg::ST_DB_WR:
            begin
                ev_d[`ISC_E_SVC] = 1'b1;
                st_d = isc_pkg::ST_IDLE;
            end
            isc_pkg::ST_CR2_WR:
            begin
                if (op_q == isc_pkg::OP_SVC)
                begin
                    ev_d[`ISC_E_SVC] = 1'b1;
                    st_d = isc_pkg::ST_IDLE;
                end
                else
                begin
                    pha_d = (op_q == isc_pkg::OP_STOP);
                    st_d = isc_pkg::ST_SR_ISSUE;
                end
            end
            isc_pkg::ST_SETUP:
            begin
                // Repeated-start setup wait, then software may start
                if (cnt_q >= need - 16'h0001)
                begin
                    ev_d[`ISC_E_RST] = 1'b1;
                    st_d = isc_pkg::ST_IDLE;
                end
            end
            isc_pkg::ST_OAR_WR:
                st_d = isc_pkg::ST_IDLE;
            default:
                st_d = isc_pkg::ST_IDLE;
        endcase
    end

    // ------------------------------------------------------------------
    // Device port access for the state being entered
    // ------------------------------------------------------------------
    always_comb
    begin
        req_d = '0;
        case (st_d)
            isc_pkg::ST_SR_ISSUE:
            begin
                req_d.rd = 1'b1;
                req_d.addr = `ISC_DV_SR2;
            end
            isc_pkg::ST_CR1:
            begin
                req_d.wr = 1'b1;
                req_d.addr = `ISC_DV_CR1;
                req_d.wdata = cr1_q;
            end
            isc_pkg::ST_DB_ISSUE:
            begin
                req_d.rd = 1'b1;
                req_d.addr = `ISC_DV_DBR;
            end
            isc_pkg::ST_DB_WR:
            begin
                req_d.wr = 1'b1;
                req_d.addr = `ISC_DV_DBR;
                req_d.wdata = txw_d ? tx_q : `ISC_DUMMY;
            end
            isc_pkg::ST_CR2_WR:
            begin
                // One write holds the whole stop or release pattern
                req_d.wr = 1'b1;
                req_d.addr = `ISC_DV_CR2;
                req_d.wdata = (op_d == isc_pkg::OP_STOP) ?
                    `ISC_CR2_STOP : `ISC_CR2_PIN;
            end
            isc_pkg::ST_OAR_WR:
            begin
                req_d.wr = 1'b1;
                req_d.addr = `ISC_DV_OAR;
                req_d.wdata = oar_q;
            end
            default:
                req_d = '0;
        endcase
    end

    // ------------------------------------------------------------------
    // Sequencer registers
    // ------------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            st_q <= isc_pkg::ST_IDLE;
            op_q <= isc_pkg::OP_SVC;
            pha_q <= 1'b0;
            txw_q <= 1'b0;
            rxp_q <= 1'b0;
            req_q <= '0;
        end
        else
        begin
            st_q <= st_d;
            op_q <= op_d;
            pha_q <= pha_d;
            txw_q <= txw_d;
            rxp_q <= rxp_d;
            req_q <= req_d;
        end
    end

    // Setup counter runs only inside the wait state
    always_ff @(posedge mclk)
    begin
        if (srst || st_q != isc_pkg::ST_SETUP)
            cnt_q <= 16'h0000;
        else
            cnt_q <= cnt_q + 16'h0001;
    end

    // Captured device words
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            sr_q <= 8'h00;
            rx_q <= 8'h00;
        end
        else
        begin
            if (st_q == isc_pkg::ST_SR_TAKE)
                sr_q <= dv_rdata;
            if (st_q == isc_pkg::ST_DB_TAKE)
                rx_q <= dv_rdata;
        end
    end

    // ------------------------------------------------------------------
    // Software registers, events and interrupt
    // ------------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            tx_q <= 8'h00;
            oar_q <= 8'h00;
            cr1_q <= 8'h00;
            mask_q <= '0;
            fast_q <= 1'b0;
            mrx_q <= 1'b0;
        end
        else if (cpu_wr)
        begin
            case (cpu_addr)
                `ISC_R_CTRL:
                begin
                    fast_q <= cpu_wdata[`ISC_C_FAST];
                    mrx_q <= cpu_wdata[`ISC_C_MRX];
                end
                `ISC_R_MASK: mask_q <= cpu_wdata[`ISC_NEV-1:0];
                `ISC_R_TX: tx_q <= cpu_wdata;
                `ISC_R_OAR: oar_q <= cpu_wdata;
                `ISC_R_CR1: cr1_q <= cpu_wdata;
                default: ;
            endcase
        end
    end

    // Sticky events: a set in the clearing cycle wins
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            ev_q <= '0;
            irq_q <= 1'b0;
        end
        else
        begin
            if (cpu_wr && cpu_addr == `ISC_R_EV)
                ev_q <= (ev_q & ~cpu_wdata[`ISC_NEV-1:0]) | ev_d;
            else
                ev_q <= ev_q | ev_d;
            irq_q <= |(ev_q & mask_q);
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge mclk)
    begin
        if (srst || !cpu_rd)
            rdata_q <= 8'h00;
        else
        begin
            case (cpu_addr)
                `ISC_R_CTRL: rdata_q <= {3'h0, mrx_q, fast_q, 3'h0};
                `ISC_R_SR: rdata_q <= sr_q;
                `ISC_R_EV: rdata_q <= 8'(ev_q);
                `ISC_R_MASK: rdata_q <= 8'(mask_q);
                `ISC_R_TX: rdata_q <= tx_q;
                `ISC_R_RX: rdata_q <= rx_q;
                `ISC_R_OAR: rdata_q <= oar_q;
                `ISC_R_CR1: rdata_q <= cr1_q;
                `ISC_R_STATE: rdata_q <= {4'h0, st_q};
                default: rdata_q <= 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    chk_status_first: assert property (
        (st_q == isc_pkg::ST_IDLE && pend_q) |=>
            (req_q.rd && req_q.addr == `ISC_DV_SR2))
        else $error("status not read first");
    chk_tx_load: assert property (
        (st_q == isc_pkg::ST_SR_TAKE && op_q == isc_pkg::OP_SVC &&
         dv_rdata[`ISC_B_TRX] && dv_rdata[`ISC_B_AAS] &&
         !dv_rdata[`ISC_B_MST]) |=> hits(req_q, `ISC_DV_CR1) ##1
            (hits(req_q, `ISC_DV_DBR) && req_q.wdata == tx_q))
        else $error("transmit load missing");
    chk_nack_release: assert property (
        (st_q == isc_pkg::ST_SR_TAKE && op_q == isc_pkg::OP_SVC &&
         dv_rdata[`ISC_B_TRX] && !dv_rdata[`ISC_B_AAS] &&
         dv_rdata[`ISC_B_LRB] && !dv_rdata[`ISC_B_MST]) |=>
            (hits(req_q, `ISC_DV_CR2) && req_q.wdata == `ISC_CR2_PIN))
        else $error("bus not released on nack");
    chk_dummy_resume: assert property (
        (st_q == isc_pkg::ST_SR_TAKE && op_q == isc_pkg::OP_SVC &&
         !dv_rdata[`ISC_B_MST] && !dv_rdata[`ISC_B_TRX] &&
         (dv_rdata[`ISC_B_AL] || dv_rdata[`ISC_B_AAS])) |=>
            (hits(req_q, `ISC_DV_DBR) && req_q.wdata == `ISC_DUMMY))
        else $error("dummy resume missing");
    chk_rx_dummy: assert property (
        (req_q.rd && req_q.addr == `ISC_DV_DBR) |-> ##2
            (hits(req_q, `ISC_DV_DBR) && req_q.wdata == `ISC_DUMMY))
        else $error("no dummy after receive");
    chk_own_nonzero: assert property (
        hits(req_q, `ISC_DV_OAR) |-> req_q.wdata != `ISC_ZERO_ADDR)
        else $error("own address zero written");
    chk_stop_write: assert property (
        (hits(req_q, `ISC_DV_CR2) && op_q == isc_pkg::OP_STOP) |->
            (req_q.wdata == `ISC_CR2_STOP && sr_q[`ISC_B_BB]))
        else $error("bad stop request");
    chk_stop_hold: assert property (
        (op_q == isc_pkg::OP_STOP && pha_q) |-> !hits(req_q, `ISC_DV_CR2))
        else $error("control touched during stop");
    chk_restart_write: assert property (
        (hits(req_q, `ISC_DV_CR2) && op_q == isc_pkg::OP_RST) |->
            (req_q.wdata == `ISC_CR2_PIN &&
             $past(st_q) == isc_pkg::ST_IDLE))
        else $error("bad restart release");
    chk_busy_polled: assert property (
        ($rose(pha_q) && op_q == isc_pkg::OP_RST) |-> !sr_q[`ISC_B_BB])
        else $error("busy not low before line check");
    chk_line_free: assert property (
        (st_q == isc_pkg::ST_SETUP && $past(st_q) == isc_pkg::ST_SR_TAKE)
            |-> (mrx_q ? $past(scl_s_q) : sr_q[`ISC_B_LRB]))
        else $error("setup entered with line held");
    chk_setup_wait: assert property (
        (st_q == isc_pkg::ST_SETUP ##1 ev_q[`ISC_E_RST] &&
         !$past(ev_q[`ISC_E_RST])) |-> $past(cnt_q) + 16'h0001 >= need)
        else $error("setup wait too short");

    cov_stop: cover property (ev_d[`ISC_E_STOP]);
    cov_restart: cover property (ev_d[`ISC_E_RST]);
    cov_rx: cover property (ev_d[`ISC_E_RX]);
    cov_tx: cover property (hits(req_q, `ISC_DV_DBR) && txw_q);
endmodule
`default_nettype wire

/* File: bench/isc_dev_model.sv */
// Behavioural model of the bus interface registers seen by the host
`timescale 1ns/1ps
`default_nettype none
module isc_dev_model #(
    parameter int M_CYC = 6
) (
    input wire logic mclk,
    input wire isc_pkg::isc_dev_req_t dv_req,
    input wire logic scl_pin,
    output logic [7:0] dv_rdata
);
    // -------------------------------------------------------------
    // Registers and the delayed bus release
    // -------------------------------------------------------------
    logic [7:0] regs [0:7]; // Device registers, status at index 2
    logic [7:0] last_wr [0:7]; // Last write per index, for the bench
    int cnt = 0; // Release countdown, clock-high cycles for a stop, every cycle for a restart; zero when nothing pending
    logic stp = 1'b0; // Countdown ends a stop, not a restart
    initial dv_rdata = 8'h5a;
    // Accesses; read data lives one cycle, then keeps changing
    always @(posedge mclk)
    begin
        dv_rdata <= ~dv_rdata;
        if (dv_req.rd)
            dv_rdata <= regs[dv_req.addr];
        if (dv_req.wr)
        begin
            last_wr[dv_req.addr] <= dv_req.wdata;
            if (dv_req.addr == 3'h1 && dv_req.wdata == 8'hd0 && regs[2][5])
            begin
                cnt <= M_CYC;
                stp <= 1'b1;
            end
            else if (dv_req.addr == 3'h1 && dv_req.wdata == 8'h10)
            begin
                cnt <= M_CYC;
                stp <= 1'b0;
            end
            if (dv_req.addr == 3'h3)
                regs[2][3] <= 1'b0;
            // Data write or pending bit ends the clock stretch
            if (dv_req.addr == 3'h3 ||
                (dv_req.addr == 3'h1 && dv_req.wdata[4]))
                regs[2][4] <= 1'b1;
        end
        // Only a stop waits for a clock line held low elsewhere; a
        // restart frees the own pin after M_CYC cycles while the line may stay low
        if (cnt > 0 && (scl_pin || !stp))
            cnt <= cnt - 1;
        if (cnt == 1 && (scl_pin || !stp))
        begin
            regs[2][5] <= 1'b0;
            if (scl_pin)
                regs[2][0] <= 1'b1;
        end
    end
endmodule
`default_nettype wire

/* File: bench/testbench.sv */
// Self-checking bench for the bus interface host controller
`timescale 1ns/1ps
`default_nettype none
`include "isc_regs.svh"
`define CHK(nm, e, s) begin n_tests++; if ((e) !== (s)) begin miscompares++; \
    $display("BAD %s exp %h got %h", nm, e, s); end end
module testbench;
    // -------------------------------------------------------------
    // Stimulus signals and instances
    // -------------------------------------------------------------
    logic mclk = 0, srst = 1, cpu_wr = 0, cpu_rd = 0, dv_irq = 0, scl_pin = 1;
    logic [3:0] cpu_addr = 4'h0;
    logic [7:0] cpu_wdata = 8'h00, cpu_rdata, dv_rdata, d, tx;
    logic irq;
    logic [15:0] ex;
    isc_pkg::isc_dev_req_t dv_req;
    int miscompares = 0, n_tests = 0, seed = 32'hdde4, i;
    logic [7:0] sts [0:5] = '{8'h00, 8'h44, 8'h0c, 8'h08, 8'h41, 8'h80};
    always #2.5 mclk = ~mclk;
    // Short setup counts keep the restart quick
    isc_host #(.TSU_STD_CYC(4), .TSU_FAST_CYC(2)) dut_u (.mclk(mclk),
        .srst(srst), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
        .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata), .irq(irq),
        .dv_req(dv_req), .dv_rdata(dv_rdata), .dv_irq(dv_irq),
        .scl_pin(scl_pin));
    isc_dev_model #(.M_CYC(6)) m_u (.mclk(mclk), .dv_req(dv_req),
        .scl_pin(scl_pin), .dv_rdata(dv_rdata));
    // -------------------------------------------------------------
    // Bus tasks and expectations
    // -------------------------------------------------------------
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge mclk);
        cpu_addr <= a;
        cpu_wdata <= v;
        cpu_wr <= 1'b1;
        @(posedge mclk);
        cpu_wr <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe; it is taken
    // at the edge that closes that cycle
    task automatic rd(input logic [3:0] a);
        @(posedge mclk);
        cpu_addr <= a;
        cpu_rd <= 1'b1;
        @(posedge mclk);
        cpu_rd <= 1'b0;
        @(posedge mclk);
        d = cpu_rdata;
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Bounded poll of one event bit; a hang ends the run
    task automatic wait_ev(input int b);
        int k;
        for (k = 0; k < 400; k++)
        begin
            rd(`ISC_R_EV);
            if (d[b] === 1'b1)
                return;
        end
        miscompares++;
        results();
    endtask
    // Expected writes {command, data}; 8'hee means untouched
    function automatic logic [15:0] exp_wr(input logic [7:0] st,
        input logic [7:0] t);
        if (st[7])
            return 16'heeee;
        if (st[6] && !st[2] && st[0])
            return {8'h10, 8'hee};
        return {8'hee, st[6] ? t : 8'h00};
    endfunction
    // -------------------------------------------------------------
    // Main sequence
    // -------------------------------------------------------------
    initial
    begin
        repeat (12) @(posedge mclk);
        srst <= 1'b0;
        rd(`ISC_R_MASK);
        `CHK("mask", 8'h00, d)
        rd(4'hf);
        `CHK("unmapped", 8'h00, d)
        wr(`ISC_R_MASK, 8'h01);
        for (i = 0; i < 12; i++)
        begin
            tx = $random(seed);
            wr(`ISC_R_TX, tx);
            m_u.regs[2] = sts[i % 6];
            m_u.last_wr[1] = 8'hee;
            m_u.last_wr[3] = 8'hee;
            m_u.regs[3] = $random(seed);
            dv_irq <= 1'b1;
            wait_ev(`ISC_E_SVC);
            dv_irq <= 1'b0;
            `CHK("irq", 1'b1, irq)
            ex = exp_wr(sts[i % 6], tx);
            `CHK("cmd", ex[15:8], m_u.last_wr[1])
            `CHK("data", ex[7:0], m_u.last_wr[3])
            rd(`ISC_R_RX);
            if (sts[i % 6] == 8'h00)
                `CHK("rx", m_u.regs[3], d)
            wr(`ISC_R_EV, 8'h1f);
            rd(`ISC_R_EV);
            `CHK("irq clr", 1'b0, irq)
        end
        // Stop held off while another party holds the clock low
        m_u.regs[2] = 8'ha0;
        scl_pin <= 1'b0;
        wr(`ISC_R_CTRL, 8'h01);
        repeat (40) @(posedge mclk);
        `CHK("stop cmd", 8'hd0, m_u.last_wr[1])
        rd(`ISC_R_EV);
        `CHK("held", 1'b0, d[`ISC_E_STOP])
        scl_pin <= 1'b1;
        wait_ev(`ISC_E_STOP);
        wr(`ISC_R_EV, 8'h1f);
        wr(`ISC_R_CTRL, 8'h01);
        wait_ev(`ISC_E_ERR);
        // Own address zero is refused
        wr(`ISC_R_EV, 8'h1f);
        m_u.last_wr[4] = 8'hee;
        wr(`ISC_R_OAR, 8'h00);
        wr(`ISC_R_CTRL, 8'h04);
        wait_ev(`ISC_E_ERR);
        `CHK("oar", 8'hee, m_u.last_wr[4])
        // Restart: release, busy clear, then line free
        wr(`ISC_R_EV, 8'h1f);
        m_u.regs[2] = 8'ha0;
        wr(`ISC_R_CTRL, 8'h02);
        wait_ev(`ISC_E_RST);
        `CHK("rst cmd", 8'h10, m_u.last_wr[1])
        // After master receive the nack leaves the last bit high, so
        // only the clock line level may let the restart go on
        wr(`ISC_R_EV, 8'h1f);
        m_u.regs[2] = 8'ha1;
        scl_pin <= 1'b0;
        wr(`ISC_R_CTRL, 8'h1a);
        repeat (40) @(posedge mclk);
        rd(`ISC_R_EV);
        `CHK("line held", 1'b0, d[`ISC_E_RST])
        rd(`ISC_R_CTRL);
        `CHK("ctrl", 8'h18, d)
        scl_pin <= 1'b1;
        wait_ev(`ISC_E_RST);
        results();
    end
endmodule
`default_nettype wire
